/* File: card_host_status_irq.sv */
// Function
// R1: control bit 7 gates card clocks
// R2: control bit 6 resets data controller
// R3: control bit 5 resets command controller
// R4: reserved control and status bits read zero
// R5: data delay three plus two per code
// R6: control bit 0 enables flow control
// R7: flow control stops clock on fifo pair
// R8: status bit 5 follows card busy
// R9: status bit 4 shows data crc result
// R10: status bit 3 shows data format result
// R11: status bit 2 shows response crc7 result
// R12: status bit 1 shows response format result
// R13: status bit 0 shows command fifo busy
// R14: flag 7 sets on busy change
// R15: flag 6 sets at response end
// R16: flag 5 sets at command end
// R17: flag 4 sets at frame end
// R18: flag register read clears flags 7-4
// R19: flag 3 second fifo full, empty clears
// R20: flag 2 first fifo full, empty clears
// R21: flag 1 second fifo empty, full clears
// R22: flag 0 first fifo empty, full clears
// R23: unmasked set flag raises interrupt request
// R24: status register ignores software writes
`timescale 1ns/1ns
`default_nettype none

module card_host_status_irq (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // special function register port
  input wire card_host_pkg::sfr_req_s sfr,
  output logic [7:0] sfr_rdata,
  // card pins
  input wire logic card_clk,
  input wire logic card_dat0,
  // line controller side
  input wire card_host_pkg::ctrl_event_s events,
  input wire card_host_pkg::fifo_level_s fifo_level,
  input wire card_host_pkg::check_result_s checks,
  input wire logic data_dir_tx,
  input wire logic cmd_fifo_busy,
  input wire logic irq_global_enable,
  // controls to the card side
  output logic card_clk_run,
  output logic data_ctrl_reset,
  output logic cmd_ctrl_reset,
  output logic flow_control_enable,
  output logic data_tx_start,
  output logic irq
);
  import card_host_pkg::*;

  logic [7:0] card_control_two; // software control bits
  logic [7:0] card_int_mask; // set bit blocks its flag
  logic [7:0] card_status; // hardware status, read only
  logic [7:0] card_interrupt_flags; // sticky event flags
  logic [7:0] next_flags; // flags after this cycle
  logic card_busy_flag; // card holds data line low
  logic busy_rise; // busy entered
  logic busy_fall; // busy left
  logic clk_rise; // card clock rising edge
  fifo_level_s fifo_prev; // fifo levels one cycle ago
  logic [3:0] delay_count; // card periods still to wait
  logic delay_running; // delay counter armed
  logic flow_stop; // flow control holds the clock
  logic wr_ctl; // write to control register
  logic wr_mask; // write to mask register
  logic rd_flags; // read of flag register

  // register decode
  assign wr_ctl = sfr.wr && sfr.addr == ADDR_CARD_CONTROL_TWO;
  assign wr_mask = sfr.wr && sfr.addr == ADDR_CARD_INT_MASK;
  assign rd_flags = sfr.rd && sfr.addr == ADDR_CARD_INT_FLAGS;

  // busy is the data line held low by the card
  pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_dat0_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pin(card_dat0),
    .level(),
    .rise(busy_fall),
    .fall(busy_rise)
  );

  // card clock is only sampled, edges drive the delay counter
  pin_sync #(
    .RESET_LEVEL(1'b0)
  ) u_clk_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pin(card_clk),
    .level(),
    .rise(clk_rise),
    .fall()
  );

  // busy level kept from the filtered edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      card_busy_flag <= 1'b0;
    end else if (busy_rise) begin
      card_busy_flag <= 1'b1; // R8
    end else if (busy_fall) begin
      card_busy_flag <= 1'b0; // R8
    end
  end

  // control register, reserved bits never stored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      card_control_two <= CTL_RESET;
    end else if (wr_ctl) begin
      card_control_two <= sfr.wdata & CTL_WRITABLE; // R4
    end
  end

  // mask register, all sources masked from reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      card_int_mask <= MASK_RESET;
    end else if (wr_mask) begin
      card_int_mask <= sfr.wdata;
    end
  end

  // control outputs; resets stay asserted as long as software holds the bit
  assign data_ctrl_reset = card_control_two[CTL_DATA_RESET]; // R2
  assign cmd_ctrl_reset = card_control_two[CTL_CMD_RESET]; // R3
  assign flow_control_enable = card_control_two[CTL_FLOW]; // R6

  // flow control looks at the flags, so it releases on the flag clear
  always_comb begin
    flow_stop = 1'b0;
    if (card_control_two[CTL_FLOW]) begin // R6
      if (data_dir_tx) begin
        flow_stop = card_interrupt_flags[INT_FIFO_ONE_EMPTY]
                    && card_interrupt_flags[INT_FIFO_TWO_EMPTY]; // R7
      end else begin
        flow_stop = card_interrupt_flags[INT_FIFO_ONE_FULL]
                    && card_interrupt_flags[INT_FIFO_TWO_FULL]; // R7
      end
    end
  end

  // clock gate: stopped when disabled or held by flow control
  assign card_clk_run = card_control_two[CTL_CLOCK_ENABLE] && !flow_stop; // R1

  // status: the controllers own these bits, software writes never reach them
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      card_status <= STA_RESET;
    end else begin
      card_status[7:6] <= 2'b00; // R4
      card_status[STA_CARD_BUSY] <= card_busy_flag; // R8
      card_status[STA_CMD_LOCK] <= cmd_fifo_busy; // R13
      if (events.frame_done) begin
        // token answer when sending, own check when receiving
        card_status[STA_DATA_CRC] <= data_dir_tx ? checks.token_crc_ok
                                                 : checks.rx_crc_ok; // R9
        card_status[STA_DATA_FORMAT] <= data_dir_tx ? checks.token_format_ok
                                                    : checks.rx_format_ok; // R10
      end
      if (events.resp_done) begin
        // meaningless while crc7 checking is off, but still captured
        card_status[STA_RESP_CRC] <= checks.resp_crc_ok; // R11
        card_status[STA_RESP_FORMAT] <= checks.resp_format_ok; // R12
      end
    end
  end

  // fifo levels one cycle back for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fifo_prev <= '0;
    end else begin
      fifo_prev <= fifo_level;
    end
  end

  // flag update: the read clear comes first, so a set in the same cycle wins over it
  always_comb begin
    next_flags = card_interrupt_flags;
    if (rd_flags) begin
      next_flags = next_flags & ~INT_READ_CLEAR; // R18
    end
    if (fifo_level.two_empty && !fifo_prev.two_empty) begin
      next_flags[INT_FIFO_TWO_FULL] = 1'b0; // R19
      next_flags[INT_FIFO_TWO_EMPTY] = 1'b1; // R21
    end
    if (fifo_level.one_empty && !fifo_prev.one_empty) begin
      next_flags[INT_FIFO_ONE_FULL] = 1'b0; // R20
      next_flags[INT_FIFO_ONE_EMPTY] = 1'b1; // R22
    end
    if (fifo_level.two_full && !fifo_prev.two_full) begin
      next_flags[INT_FIFO_TWO_FULL] = 1'b1; // R19
      next_flags[INT_FIFO_TWO_EMPTY] = 1'b0; // R21
    end
    if (fifo_level.one_full && !fifo_prev.one_full) begin
      next_flags[INT_FIFO_ONE_FULL] = 1'b1; // R20
      next_flags[INT_FIFO_ONE_EMPTY] = 1'b0; // R22
    end
    if (busy_rise || busy_fall) begin
      next_flags[INT_BUSY_CHANGE] = 1'b1; // R14
    end
    if (events.resp_done) begin
      next_flags[INT_RESP_DONE] = 1'b1; // R15
    end
    if (events.cmd_done) begin
      next_flags[INT_CMD_DONE] = 1'b1; // R16
    end
    if (events.frame_done) begin
      next_flags[INT_FRAME_DONE] = 1'b1; // R17
    end
  end

  // flag register; writes are simply not decoded
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      card_interrupt_flags <= INT_RESET;
    end else begin
      card_interrupt_flags <= next_flags; // R18
    end
  end

  // request while any unmasked flag is set and the global enable is on
  assign irq = irq_global_enable && |(card_interrupt_flags & ~card_int_mask); // R23

  // delay counter in card clock periods, frozen while the clock is gated
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      delay_count <= 4'h0;
      delay_running <= 1'b0;
      data_tx_start <= 1'b0;
    end else begin
      data_tx_start <= 1'b0;
      if (card_control_two[CTL_DATA_RESET]) begin
        delay_running <= 1'b0; // R2
        delay_count <= 4'h0;
      end else if (events.resp_done && data_dir_tx) begin
        delay_count <= delay_periods(card_control_two[CTL_DELAY_HI:CTL_DELAY_LO]); // R5
        delay_running <= 1'b1;
      end else if (delay_running && clk_rise && card_clk_run) begin // R1
        delay_count <= delay_count - 4'h1;
        if (delay_count == 4'h1) begin
          delay_running <= 1'b0;
          data_tx_start <= 1'b1; // R5
        end
      end
    end
  end

  // read data from a register; unmapped addresses answer zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= UNMAPPED_READ;
    end else if (sfr.rd) begin
      case (sfr.addr)
        ADDR_CARD_CONTROL_TWO: begin
          sfr_rdata <= card_control_two & CTL_WRITABLE; // R4
        end
        ADDR_CARD_STATUS: begin
          sfr_rdata <= card_status; // R24
        end
        ADDR_CARD_INT_FLAGS: begin
          sfr_rdata <= card_interrupt_flags;
        end
        ADDR_CARD_INT_MASK: begin
          sfr_rdata <= card_int_mask;
        end
        default: begin
          sfr_rdata <= UNMAPPED_READ;
        end
      endcase
    end
  end

  // named steps for the checks below
  sequence ctl_write_s;
    wr_ctl;
  endsequence

  sequence resp_end_tx_s;
    events.resp_done && data_dir_tx && !card_control_two[CTL_DATA_RESET];
  endsequence

  sequence quiet_flags_s;
    !busy_rise && !busy_fall && !events.resp_done && !events.cmd_done
      && !events.frame_done;
  endsequence

  clock_gate_a: assert property (@(posedge mclk) disable iff (!rstn) // R1
    !card_control_two[CTL_CLOCK_ENABLE] |-> !card_clk_run)
    else $error("card clock runs while disabled");

  data_reset_a: assert property (@(posedge mclk) disable iff (!rstn) // R2
    data_ctrl_reset |=> !delay_running && !data_tx_start)
    else $error("data controller not held in reset");

  cmd_reset_a: assert property (@(posedge mclk) disable iff (!rstn) // R3
    ctl_write_s |=> cmd_ctrl_reset == $past(sfr.wdata[CTL_CMD_RESET]))
    else $error("command reset does not follow the write");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // R4
    sfr.rd && (sfr.addr == ADDR_CARD_CONTROL_TWO || sfr.addr == ADDR_CARD_STATUS)
      |=> ($past(sfr.addr) == ADDR_CARD_STATUS) ? sfr_rdata[7:6] == 2'b00
      : sfr_rdata[4:3] == 2'b00)
    else $error("reserved bits read nonzero");

  delay_load_a: assert property (@(posedge mclk) disable iff (!rstn) // R5
    resp_end_tx_s |=> delay_running
      && delay_count == delay_periods($past(card_control_two[2:1])))
    else $error("delay loaded with wrong period count");

  flow_stop_a: assert property (@(posedge mclk) disable iff (!rstn) // R7
    card_control_two[CTL_FLOW] && data_dir_tx
      && card_interrupt_flags[INT_FIFO_ONE_EMPTY]
      && card_interrupt_flags[INT_FIFO_TWO_EMPTY] |-> !card_clk_run)
    else $error("clock not stopped with both fifos empty");

  busy_change_a: assert property (@(posedge mclk) disable iff (!rstn) // R14
    (busy_rise || busy_fall) |=> card_interrupt_flags[INT_BUSY_CHANGE] ##1
      card_status[STA_CARD_BUSY] == card_busy_flag)
    else $error("busy change flag missed");

  read_clear_a: assert property (@(posedge mclk) disable iff (!rstn) // R18
    (rd_flags and quiet_flags_s) |=> card_interrupt_flags[7:4] == 4'h0)
    else $error("read did not clear event flags");

  fifo_full_a: assert property (@(posedge mclk) disable iff (!rstn) // R19
    fifo_level.two_full && !fifo_prev.two_full |=>
      card_interrupt_flags[INT_FIFO_TWO_FULL] && !card_interrupt_flags[INT_FIFO_TWO_EMPTY])
    else $error("second fifo full flag wrong");

  irq_out_a: assert property (@(posedge mclk) disable iff (!rstn) // R23
    events.cmd_done |=> irq || !irq_global_enable || card_int_mask[INT_CMD_DONE])
    else $error("unmasked flag raised no request");

  status_ro_a: assert property (@(posedge mclk) disable iff (!rstn) // R24
    (sfr.wr && sfr.addr == ADDR_CARD_STATUS && $stable(cmd_fifo_busy)
      && $stable(card_busy_flag)) and quiet_flags_s |=> $stable(card_status))
    else $error("status changed by a write");

endmodule

`default_nettype wire

/* File: card_host_pkg.sv */
package card_host_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_CARD_INT_MASK = 8'hDF;
  localparam logic [7:0] ADDR_CARD_STATUS = 8'hDE;
  localparam logic [7:0] ADDR_CARD_CONTROL_TWO = 8'hE6;
  localparam logic [7:0] ADDR_CARD_INT_FLAGS = 8'hE7;

  // second control register fields
  localparam int unsigned CTL_CLOCK_ENABLE = 7;
  localparam int unsigned CTL_DATA_RESET = 6;
  localparam int unsigned CTL_CMD_RESET = 5;
  localparam int unsigned CTL_DELAY_HI = 2;
  localparam int unsigned CTL_DELAY_LO = 1;
  localparam int unsigned CTL_FLOW = 0;
  localparam logic [7:0] CTL_WRITABLE = 8'hE7;

  // status register fields
  localparam int unsigned STA_CARD_BUSY = 5;
  localparam int unsigned STA_DATA_CRC = 4;
  localparam int unsigned STA_DATA_FORMAT = 3;
  localparam int unsigned STA_RESP_CRC = 2;
  localparam int unsigned STA_RESP_FORMAT = 1;
  localparam int unsigned STA_CMD_LOCK = 0;

  // interrupt flag fields
  localparam int unsigned INT_BUSY_CHANGE = 7;
  localparam int unsigned INT_RESP_DONE = 6;
  localparam int unsigned INT_CMD_DONE = 5;
  localparam int unsigned INT_FRAME_DONE = 4;
  localparam int unsigned INT_FIFO_TWO_FULL = 3;
  localparam int unsigned INT_FIFO_ONE_FULL = 2;
  localparam int unsigned INT_FIFO_TWO_EMPTY = 1;
  localparam int unsigned INT_FIFO_ONE_EMPTY = 0;
  localparam logic [7:0] INT_READ_CLEAR = 8'hF0;

  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] STA_RESET = 8'h00;
  localparam logic [7:0] INT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // data transmission delay, in card clock periods
  localparam logic [3:0] DELAY_BASE_PERIODS = 4'h3;
  localparam logic [3:0] DELAY_STEP_PERIODS = 4'h2;

  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // processor access to the special function registers
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

  // one-cycle completion pulses from the line controllers
  typedef struct packed {
    logic resp_done;
    logic cmd_done;
    logic frame_done;
  } ctrl_event_s;

  // fifo levels from the data fifo pair
  typedef struct packed {
    logic one_full;
    logic one_empty;
    logic two_full;
    logic two_empty;
  } fifo_level_s;

  // check results, valid with the matching completion pulse
  typedef struct packed {
    logic token_crc_ok;
    logic token_format_ok;
    logic rx_crc_ok;
    logic rx_format_ok;
    logic resp_crc_ok;
    logic resp_format_ok;
  } check_result_s;

  // card clock periods between response end and data start
  function automatic logic [3:0] delay_periods(input logic [1:0] code);
    return 4'(DELAY_BASE_PERIODS + DELAY_STEP_PERIODS * {2'b00, code});
  endfunction

endpackage

/* File: pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // raw pin level
  input wire logic pin,
  // filtered level and its edges
  output logic level,
  output logic rise,
  output logic fall
);
  import card_host_pkg::*;

  // stage one is read only by stage two
  logic [SYNC_STAGES-1:0] stage;

  initial begin
    if (SYNC_STAGES != 3) begin
      $error("pin_sync needs exactly three stages");
    end
  end

  // shift chain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage <= {SYNC_STAGES{RESET_LEVEL}};
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], pin};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      level <= RESET_LEVEL;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (stage[1] == stage[2] && stage[2] != level) begin
        level <= stage[2];
        rise <= stage[2];
        fall <= !stage[2];
      end
    end
  end

endmodule

`default_nettype wire

/* File: card_model.sv */
`timescale 1ns/1ns
`default_nettype none

module card_model (
  // commands from the bench
  input wire logic run_clk,
  input wire logic busy,
  // card pins
  output logic card_clk,
  output logic card_dat0
);
  // clock idles low between frames, a started period always completes
  initial begin
    card_clk = 1'b0;
    forever begin
      wait (run_clk);
      #80 card_clk = 1'b1;
      #80 card_clk = 1'b0;
    end
  end

  // data line has a pull-up, so a released line reads high
  assign card_dat0 = busy ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: card_host_status_irq_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module card_host_status_irq_tb_top;
  import card_host_pkg::*;
  // clock, reset and counters
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  int rises = 0;
  int starts = 0;
  // stimulus, all given a value at time zero
  sfr_req_s sfr = '0;
  ctrl_event_s events = '0;
  fifo_level_s fifo_level = '0;
  check_result_s checks = '0;
  logic data_dir_tx = 1'b0;
  logic cmd_fifo_busy = 1'b0;
  logic irq_global_enable = 1'b0;
  logic run_clk = 1'b0;
  logic busy = 1'b0;
  // observed
  logic [7:0] sfr_rdata;
  logic card_clk;
  logic card_dat0;
  logic card_clk_run;
  logic data_ctrl_reset;
  logic cmd_ctrl_reset;
  logic flow_control_enable;
  logic data_tx_start;
  logic irq;
  wire logic [7:0] outs;

  // control outputs packed for one compare
  assign outs = {4'h0, card_clk_run, data_ctrl_reset, cmd_ctrl_reset, flow_control_enable};

  card_host_status_irq DUT (
    .mclk(mclk),
    .rstn(rstn),
    .sfr(sfr),
    .sfr_rdata(sfr_rdata),
    .card_clk(card_clk),
    .card_dat0(card_dat0),
    .events(events),
    .fifo_level(fifo_level),
    .checks(checks),
    .data_dir_tx(data_dir_tx),
    .cmd_fifo_busy(cmd_fifo_busy),
    .irq_global_enable(irq_global_enable),
    .card_clk_run(card_clk_run),
    .data_ctrl_reset(data_ctrl_reset),
    .cmd_ctrl_reset(cmd_ctrl_reset),
    .flow_control_enable(flow_control_enable),
    .data_tx_start(data_tx_start),
    .irq(irq)
  );

  card_model card (
    .run_clk(run_clk),
    .busy(busy),
    .card_clk(card_clk),
    .card_dat0(card_dat0)
  );

  // 100 MHz system clock
  always #5 mclk = ~mclk;

  // card clock rises seen at the pin
  always @(posedge card_clk) begin
    rises++;
  end

  // start pulses, looked at mid-cycle while they stand
  always @(negedge mclk) begin
    if (data_tx_start === 1'b1) begin
      starts++;
    end
  end

  // hang guard, the whole run needs under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk);
    sfr.wr = 1'b0;
  endtask

  // one-cycle register read; data is held, so one spare cycle is harmless
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge mclk);
    sfr.rd = 1'b0;
    @(negedge mclk);
    chk(what, sfr_rdata, exp);
  endtask

  task automatic pulse(input ctrl_event_s e);
    @(negedge mclk);
    events = e;
    @(negedge mclk);
    events = '0;
  endtask

  task automatic level(input fifo_level_s f);
    @(negedge mclk);
    fifo_level = f;
    idle(2);
  endtask

  initial begin
    idle(5);
    rstn = 1'b1;
    // reset values
    rchk("control", ADDR_CARD_CONTROL_TWO, CTL_RESET);
    rchk("mask", ADDR_CARD_INT_MASK, MASK_RESET);
    rchk("status", ADDR_CARD_STATUS, STA_RESET);
    rchk("flags", ADDR_CARD_INT_FLAGS, INT_RESET);
    rchk("unmapped", 8'h00, UNMAPPED_READ);
    // control bits and reserved bits
    wr(ADDR_CARD_CONTROL_TWO, 8'hFF);
    rchk("control", ADDR_CARD_CONTROL_TWO, 8'hE7);
    chk("outputs", outs, 8'h0F);
    wr(ADDR_CARD_CONTROL_TWO, 8'h00);
    chk("outputs", outs, 8'h00);
    // read-only registers ignore writes
    wr(ADDR_CARD_STATUS, 8'hFF);
    wr(ADDR_CARD_INT_FLAGS, 8'hFF);
    rchk("status", ADDR_CARD_STATUS, 8'h00);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h00);
    cmd_fifo_busy = 1'b1;
    rchk("status", ADDR_CARD_STATUS, 8'h01);
    cmd_fifo_busy = 1'b0;
    // transmit direction results
    data_dir_tx = 1'b1;
    checks = 6'b10_01_10;
    pulse(3'b111);
    rchk("status", ADDR_CARD_STATUS, 8'h14);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h70);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h00);
    // receive direction results
    data_dir_tx = 1'b0;
    checks = 6'b01_10_01;
    pulse(3'b101);
    rchk("status", ADDR_CARD_STATUS, 8'h12);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h50);
    // card busy, both edges
    busy = 1'b1;
    idle(10);
    rchk("status", ADDR_CARD_STATUS, 8'h32);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h80);
    busy = 1'b0;
    idle(10);
    rchk("status", ADDR_CARD_STATUS, 8'h12);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h80);
    // fifo flags follow level edges, reads leave them alone
    level(4'b1000);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h04);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h04);
    level(4'b0100);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h01);
    level(4'b0110);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h09);
    level(4'b0101);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h03);
    level(4'b1001);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h06);
    level(4'b1010);
    rchk("flags", ADDR_CARD_INT_FLAGS, 8'h0C);
    // interrupt request against mask and global enable
    irq_global_enable = 1'b1;
    wr(ADDR_CARD_INT_MASK, 8'hFB);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(ADDR_CARD_INT_MASK, 8'hFE);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(ADDR_CARD_INT_MASK, 8'hFB);
    irq_global_enable = 1'b0;
    idle(1);
    chk("irq", {7'h00, irq}, 8'h00);
    // flow control, receive then transmit
    wr(ADDR_CARD_CONTROL_TWO, 8'h81);
    chk("outputs", outs, 8'h01);
    level(4'b1001);
    chk("outputs", outs, 8'h09);
    data_dir_tx = 1'b1;
    level(4'b0101);
    chk("outputs", outs, 8'h01);
    wr(ADDR_CARD_CONTROL_TWO, 8'h80);
    chk("outputs", outs, 8'h08);
    // transmission delay for every code
    for (int code = 0; code < 4; code++) begin
      wr(ADDR_CARD_CONTROL_TWO, 8'h80 | 8'(code << 1));
      pulse(3'b100);
      rises = 0;
      run_clk = 1'b1;
      for (int i = 0; i < 400 && data_tx_start !== 1'b1; i++) begin
        @(negedge mclk);
      end
      run_clk = 1'b0;
      chk("delay", 8'(rises), 8'(3 + 2 * code));
      idle(20);
    end
    // data reset drops a pending delay, no start even with the clock running
    pulse(3'b100);
    wr(ADDR_CARD_CONTROL_TWO, 8'hC0);
    wr(ADDR_CARD_CONTROL_TWO, 8'h80);
    starts = 0;
    run_clk = 1'b1;
    idle(200);
    run_clk = 1'b0;
    chk("aborted start", 8'(starts), 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
